/* File: backlight_flash_control_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module backlight_flash_control_regs_tb;
  import blf_pkg::*;
  localparam int CPM = 4;
  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  logic       pin  = 1'b0;
  logic       reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [3:0] sink_on;
  logic [4:0] bl_applied_code;
  logic [5:0] bl_current_half_ma;
  logic       fade_busy;
  logic       strobe_on;
  logic [3:0] strobe_current_50ma;
  logic       strobe_timed_out;
  logic [7:0] d;
  int         n_errors = 0;
  int         checks   = 0;
  int         seed     = 25669;
  int         cyc      = 0;
  int         c;
  int         v;
  int         ms[4]    = '{32, 24, 16, 8};

  blf_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  blf_regs #(.CYCLES_PER_MS(CPM)) uut (.mclk(mclk), .rst(rst),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .strobe_trigger_pin(pin), .sink_on(sink_on),
    .bl_applied_code(bl_applied_code), .bl_current_half_ma(bl_current_half_ma),
    .fade_busy(fade_busy), .strobe_on(strobe_on),
    .strobe_current_50ma(strobe_current_50ma),
    .strobe_timed_out(strobe_timed_out));

  always #25 mclk = ~mclk;

  // ----------------------------------------
  // reference model and helpers
  // ----------------------------------------
  function automatic logic [5:0] bl_ma(int k);
    return 6'(k < 24 ? k + 1 : k < 27 ? 2 * k - 22 : 4 * k - 74);
  endfunction

  function automatic logic [3:0] st_ma(int x);
    int k = x >> 1;
    if (x % 2)
      return 4'(k == 0 ? 0 : k < 3 ? k + 5 : 8);
    return 4'(k < 5 ? k : 5);
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wait_for(int sel, output int n);
    n = 0;
    while ((sel ? strobe_timed_out !== 1'b1 : fade_busy !== 1'b0) && n < 9000)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic defaults;
    logic [7:0] e[4] = '{8'h00, 8'h00, 8'h10, 8'h00};
    for (int a = 0; a < 4; a++)
    begin
      host.rd(8'(a), d);
      `CHK(d, e[a])
    end
  endtask

  task automatic final_report;
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    tick(12);
    @(posedge mclk) rst <= 1'b0;
    defaults();
    host.wr(8'h01, 8'hff);
    host.wr(8'h02, 8'hee);
    host.wr(8'h03, 8'h5a);
    host.rd(8'h01, d);
    `CHK(d, 8'h0f)
    host.rd(8'h02, d);
    `CHK(d, 8'h0e)
    @(posedge mclk) rst <= 1'b1;
    tick(2);
    @(posedge mclk) rst <= 1'b0;
    defaults();
    repeat (6)
    begin
      v = $random(seed);
      host.wr(8'h01, 8'(v));
      tick(2);
      `CHK(sink_on, 4'(v))
    end
    for (int k = 0; k < 32; k++)
    begin
      host.wr(8'h00, 8'(k));
      tick(3);
      `CHK(bl_applied_code, 5'(k))
      `CHK(bl_current_half_ma, bl_ma(k))
    end
    for (int r = 0; r < 4; r++)
    begin
      host.wr(8'h00, 8'(r * 64 + 62 - r));
      tick(2);
      wait_for(0, c);
      tick(2);
      `CHK(c >= ms[r] * CPM - 4 && c <= ms[r] * CPM + 8, 1'b1)
      `CHK(bl_applied_code, 5'(30 - r))
    end
    host.wr(8'h00, 8'h38);
    tick(20);
    host.wr(8'h00, 8'he0);
    wait_for(0, c);
    tick(2);
    `CHK(bl_applied_code, 5'h18)
    `CHK(c < 200, 1'b1)
    host.rd(8'h00, d);
    `CHK(d, 8'hf8)
    host.wr(8'h00, 8'h24);
    tick(300);
    host.wr(8'h00, 8'h09);
    tick(3);
    `CHK(fade_busy, 1'b0)
    `CHK(bl_applied_code, 5'h04)
    host.wr(8'h00, 8'h1f);
    tick(3);
    host.wr(8'h00, 8'he0);
    tick(2);
    wait_for(0, c);
    tick(2);
    `CHK(bl_applied_code, 5'h00)
    `CHK(c >= 31 * 8 * CPM - 4 && c <= 31 * 9 * CPM, 1'b1)
    for (int x = 0; x < 16; x++)
    begin
      host.wr(8'h02, 8'(16 + x));
      @(posedge mclk) pin <= 1'b1;
      tick(5);
      `CHK(strobe_current_50ma, st_ma(x))
      `CHK(strobe_on, 1'(x > 1))
      @(posedge mclk) pin <= 1'b0;
      tick(4);
    end
    host.wr(8'h02, 8'h12);
    @(posedge mclk) pin <= 1'b1;
    wait_for(1, c);
    `CHK(c >= 1000 * CPM && c <= 1000 * CPM + 10, 1'b1)
    `CHK(strobe_on, 1'b0)
    host.wr(8'h02, 8'h11);
    host.wr(8'h02, 8'h13);
    tick(3);
    `CHK(strobe_timed_out, 1'b0)
    wait_for(1, c);
    `CHK(c >= 500 * CPM - 8 && c <= 500 * CPM + 8, 1'b1)
    @(posedge mclk) pin <= 1'b0;
    tick(4);
    `CHK(strobe_timed_out, 1'b0)
    @(posedge mclk) pin <= 1'b1;
    tick(5);
    `CHK(strobe_on, 1'b1)
    final_report();
  end
endmodule // backlight_flash_control_regs_tb

/* File: blf_chk.sv */
`timescale 1ns/1ps

module blf_chk
  import blf_pkg::*;
#(
  parameter int CYCLES_PER_MS = BLF_CYCLES_PER_MS,
  parameter int SINKS         = 4
)(
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // register port and pin
  input wire logic             reg_wr,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic [7:0]       reg_rdata,
  input wire logic             strobe_trigger_pin,
  // sink outputs
  input wire logic [SINKS-1:0] sink_on,
  input wire logic [4:0]       bl_applied_code,
  input wire logic [5:0]       bl_current_half_ma,
  input wire logic             fade_busy,
  input wire logic             strobe_on,
  input wire logic [3:0]       strobe_current_50ma,
  input wire logic             strobe_timed_out
);
  localparam int STEP_MIN  = 8 * CYCLES_PER_MS - 2;
  localparam int FLASH_CYC = 500 * CYCLES_PER_MS + 4;
  logic [19:0] gap;
  logic [19:0] on_cnt;
  logic        flash_rng;

  function automatic logic [5:0] half_ma(logic [4:0] c);
    return 6'(c < 24 ? c + 1 : c < 27 ? 2 * c - 22 : 4 * c - 74);
  endfunction

  always_ff @(posedge mclk)
    gap <= (rst || $changed(bl_applied_code)) ? 20'h0 : gap + 20'h1;
  always_ff @(posedge mclk)
    on_cnt <= (rst || !strobe_on) ? 20'h0 : on_cnt + 20'h1;
  always_ff @(posedge mclk)
    if (rst)
      flash_rng <= 1'b0;
    else if (reg_wr && reg_addr == 8'h02)
      flash_rng <= reg_wdata[0];

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_sink_map;
    reg_wr && reg_addr == 8'h01 ##1 !(reg_wr && reg_addr == 8'h01)
      |=> sink_on == $past(reg_wdata[3:0], 2);
  endproperty
  property p_fade_step;
    $changed(bl_applied_code) && fade_busy && $past(fade_busy) |->
      bl_applied_code == $past(bl_applied_code) + 5'h1 ||
      bl_applied_code == $past(bl_applied_code) - 5'h1;
  endproperty
  property p_step_gap;
    $changed(bl_applied_code) && fade_busy |-> gap >= STEP_MIN;
  endproperty
  property p_fade_start;
    reg_wr && reg_addr == 8'h00 && reg_wdata[5] && !fade_busy &&
      reg_wdata[4:0] != bl_applied_code && !$past(reg_wr) |-> ##[1:3] fade_busy;
  endproperty
  property p_abort;
    fade_busy && reg_wr && reg_addr == 8'h00 && !reg_wdata[5]
      |-> ##[1:3] !fade_busy;
  endproperty
  property p_current_map;
    !$past(rst) && !$past(rst, 2) && $stable(bl_applied_code) &&
      bl_applied_code == $past(bl_applied_code, 2)
      |-> bl_current_half_ma == half_ma(bl_applied_code);
  endproperty
  property p_strobe_zero;
    strobe_on == (strobe_current_50ma != 4'h0);
  endproperty
  property p_strobe_rise;
    $rose(strobe_on) |-> $past(strobe_trigger_pin, 2) &&
      $past(strobe_trigger_pin, 3);
  endproperty
  property p_trip_off;
    strobe_timed_out |-> !strobe_on;
  endproperty
  property p_flash_limit;
    strobe_on && flash_rng |-> on_cnt <= FLASH_CYC;
  endproperty

  a_sink_map: assert property (p_sink_map)
    else $error("sink enables differ from written bits");
  a_fade_step: assert property (p_fade_step)
    else $error("fade step not by one");
  a_step_gap: assert property (p_step_gap)
    else $error("fade steps too close");
  a_fade_start: assert property (p_fade_start)
    else $error("fade did not start");
  a_abort: assert property (p_abort)
    else $error("fade not cancelled");
  a_current_map: assert property (p_current_map)
    else $error("backlight current decode wrong");
  a_strobe_zero: assert property (p_strobe_zero)
    else $error("strobe current and on flag disagree");
  a_strobe_rise: assert property (p_strobe_rise)
    else $error("strobe on without trigger pin");
  a_trip_off: assert property (p_trip_off)
    else $error("strobe on after time-out");
  a_flash_limit: assert property (p_flash_limit)
    else $error("flash range on too long");

  c_fade: cover property ($fell(fade_busy));
  c_trip: cover property ($rose(strobe_timed_out));
  c_abort: cover property (fade_busy && reg_wr && !reg_wdata[5]);

endmodule // blf_chk

bind blf_regs blf_chk #(
  .CYCLES_PER_MS(CYCLES_PER_MS),
  .SINKS        (SINKS)
) u_chk (.*);

/* File: blf_host_model.sv */
`timescale 1ns/1ps

module blf_host_model
  import blf_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // register port
  output logic            reg_wr    = 1'b0,
  output logic [7:0]      reg_addr  = 8'h00,
  output logic [7:0]      reg_wdata = 8'h00,
  input  wire logic [7:0] reg_rdata
);
  // one whole byte per write, held for one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1 d = reg_rdata;
  endtask
endmodule // blf_host_model

/* File: blf_ms_timer.sv */
`timescale 1ns/1ps

module blf_ms_timer
  import blf_pkg::*;
#(
  parameter int CYCLES_PER_MS = BLF_CYCLES_PER_MS,
  parameter int MS_W          = BLF_MS_W
)(
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // control
  input  wire logic            clear,
  // elapsed whole milliseconds
  output logic [MS_W-1:0]      ms_count
);

  localparam int CYC_W = $clog2(CYCLES_PER_MS + 1);
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYCLES_PER_MS - 1);

  logic [CYC_W-1:0] cycle_count;

  // ------------------------------------------------------------
  // cycle prescaler
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst || clear || cycle_count == CYC_LAST)
      cycle_count <= '0;
    else
      cycle_count <= cycle_count + CYC_W'(1);
  end

  // ------------------------------------------------------------
  // millisecond count, saturating
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst || clear)
      ms_count <= '0;
    else if (cycle_count == CYC_LAST && ms_count != '1)
      ms_count <= ms_count + MS_W'(1);
  end

endmodule // blf_ms_timer

/* File: blf_pkg.sv */
package blf_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] BLF_ADDR_BL_CTRL     = 8'h00;
  localparam logic [7:0] BLF_ADDR_SINK_CTRL   = 8'h01;
  localparam logic [7:0] BLF_ADDR_STROBE_CTRL = 8'h02;

  localparam logic [7:0] BLF_RST_BL_CTRL      = 8'h00;
  localparam logic [7:0] BLF_RST_SINK_CTRL    = 8'h00;
  localparam logic [7:0] BLF_RST_STROBE_CTRL  = 8'h10;
  localparam logic [7:0] BLF_SINK_MASK        = 8'h0f;
  localparam logic [7:0] BLF_STROBE_MASK      = 8'h1f;

  // ------------------------------------------------------------
  // field layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] fade_rate;
    logic       fade_enable;
    logic [4:0] backlight_level_code;
  } blf_bl_ctrl_s;

  typedef struct packed {
    logic [2:0] unused;
    logic       strobe_timeout_enable;
    logic [2:0] strobe_level_code;
    logic       strobe_range_select;
  } blf_strobe_ctrl_s;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          BLF_CLK_HZ        = 20000000;
  localparam int          BLF_MS_PER_S      = 1000;
  localparam int          BLF_CYCLES_PER_MS = BLF_CLK_HZ / BLF_MS_PER_S;
  localparam int          BLF_MS_W          = 11;
  localparam logic [10:0] BLF_FADE_32_MS    = 11'h020;
  localparam logic [10:0] BLF_FADE_24_MS    = 11'h018;
  localparam logic [10:0] BLF_FADE_16_MS    = 11'h010;
  localparam logic [10:0] BLF_FADE_8_MS     = 11'h008;
  localparam logic [10:0] BLF_TIMEOUT_MS    = 11'h3e8;
  localparam logic [10:0] BLF_FLASH_MAX_MS  = 11'h1f4;

  // ------------------------------------------------------------
  // current decode, backlight in 0.5 ma units, strobe in 50 ma
  // ------------------------------------------------------------
  localparam logic [4:0] BLF_BL_LINEAR_TOP = 5'h17;
  localparam logic [5:0] BLF_BL_HIGH_TABLE [8] = '{
    6'h1a, 6'h1c, 6'h1e, 6'h22, 6'h26, 6'h2a, 6'h2e, 6'h32
  };
  localparam logic [3:0] BLF_SPOT_MAX      = 4'h5;
  localparam logic [3:0] BLF_FLASH_TABLE [8] = '{
    4'h0, 4'h6, 4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8
  };

  // ------------------------------------------------------------
  // fade sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BLF_FADE_IDLE = 2'b01,
    BLF_FADE_RUN  = 2'b10
  } blf_fade_e;

endpackage

/* File: blf_regs.sv */
// Notes on behaviour
// - register 0 holds level, fade enable, rate
// - rate codes give 32, 24, 16, 8 ms
// - fade steps by one toward target code
// - fade moves one step per selected interval
// - level writes ignored while fade runs
// - clearing fade enable jumps to target
// - fade disabled applies new level at once
// - rate change takes effect mid fade
// - level code maps to sink current table
// - all enabled sinks share one current
// - register 1 has four sink enables
// - enable bits map straight onto sinks
// - timeout enable resets set, cuts at 1 s
// - tripped strobe held until pin low/level code 0
// - register 2 holds timeout, level, range
// - strobe code decoded per range table
// - flash range limited to 500 ms
// - reset returns all registers to defaults
`timescale 1ns/1ps

module blf_regs
  import blf_pkg::*;
#(
  parameter int CYCLES_PER_MS = BLF_CYCLES_PER_MS,
  parameter int SINKS         = 4
)(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // register port from serial front end
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  // trigger pin
  input  wire logic             strobe_trigger_pin,
  // backlight sinks
  output logic [SINKS-1:0]      sink_on,
  output logic      [4:0]       bl_applied_code,
  output logic      [5:0]       bl_current_half_ma,
  output logic                  fade_busy,
  // strobe sink
  output logic                  strobe_on,
  output logic      [3:0]       strobe_current_50ma,
  output logic                  strobe_timed_out
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  blf_bl_ctrl_s           bl_ctrl;
  blf_strobe_ctrl_s       strobe_ctrl;
  logic [7:0]             sink_enable_bits;
  logic [4:0]             applied;
  blf_fade_e              fade_state;
  logic                   trig_meta;
  logic                   trig_sync;
  logic                   tripped;
  logic [BLF_MS_W-1:0]    fade_ms;
  logic [BLF_MS_W-1:0]    strobe_ms;
  logic [BLF_MS_W-1:0]    step_ms;
  logic [BLF_MS_W-1:0]    limit_ms;
  logic                   limit_armed;
  logic                   wr_bl;
  logic                   wr_sink;
  logic                   wr_strobe;
  blf_bl_ctrl_s           wr_bl_val;
  blf_strobe_ctrl_s       wr_strobe_val;
  logic                   fading;
  logic                   step_due;
  logic                   strobe_request;
  logic                   strobe_active;
  logic                   trip_now;
  logic [5:0]             next_bl_current;
  logic [3:0]             next_strobe_current;
  logic [7:0]             next_rdata;

  assign wr_bl         = reg_wr && reg_addr == BLF_ADDR_BL_CTRL;
  assign wr_sink       = reg_wr && reg_addr == BLF_ADDR_SINK_CTRL;
  assign wr_strobe     = reg_wr && reg_addr == BLF_ADDR_STROBE_CTRL;
  assign wr_bl_val     = blf_bl_ctrl_s'(reg_wdata);
  assign wr_strobe_val = blf_strobe_ctrl_s'(reg_wdata & BLF_STROBE_MASK);
  assign fading        = fade_state == BLF_FADE_RUN;

  // ------------------------------------------------------------
  // trigger pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end
    else
    begin
      trig_meta <= strobe_trigger_pin;
      trig_sync <= trig_meta;
    end
  end

  // ------------------------------------------------------------
  // register 0: level, fade enable, rate
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      bl_ctrl <= blf_bl_ctrl_s'(BLF_RST_BL_CTRL);
    else if (wr_bl)
    begin
      bl_ctrl.fade_rate   <= wr_bl_val.fade_rate;
      bl_ctrl.fade_enable <= wr_bl_val.fade_enable;
      if (!fading)
        bl_ctrl.backlight_level_code <= wr_bl_val.backlight_level_code;
    end
  end

  // ------------------------------------------------------------
  // register 1: sink enables
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      sink_enable_bits <= BLF_RST_SINK_CTRL;
    else if (wr_sink)
      sink_enable_bits <= reg_wdata & BLF_SINK_MASK;
  end

  // ------------------------------------------------------------
  // register 2: strobe control
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      strobe_ctrl <= blf_strobe_ctrl_s'(BLF_RST_STROBE_CTRL);
    else if (wr_strobe)
      strobe_ctrl <= wr_strobe_val;
  end

  // ------------------------------------------------------------
  // fade step interval
  // ------------------------------------------------------------
  always_comb
  begin
    case (bl_ctrl.fade_rate)
      2'h0:    step_ms = BLF_FADE_32_MS;
      2'h1:    step_ms = BLF_FADE_24_MS;
      2'h2:    step_ms = BLF_FADE_16_MS;
      default: step_ms = BLF_FADE_8_MS;
    endcase
  end

  assign step_due = fading && fade_ms >= step_ms;

  blf_ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS),
    .MS_W          (BLF_MS_W)
  ) u_fade_timer (
    .mclk     (mclk),
    .rst      (rst),
    .clear    (!fading || step_due),
    .ms_count (fade_ms)
  );

  // ------------------------------------------------------------
  // fade sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fade_state <= BLF_FADE_IDLE;
      applied    <= BLF_RST_BL_CTRL[4:0];
    end
    else
    begin
      case (fade_state)
        BLF_FADE_IDLE:
        begin
          if (wr_bl && wr_bl_val.fade_enable &&
              wr_bl_val.backlight_level_code != applied)
            fade_state <= BLF_FADE_RUN;
          else if (wr_bl)
            applied <= wr_bl_val.backlight_level_code;
        end
        BLF_FADE_RUN:
        begin
          if (wr_bl && !wr_bl_val.fade_enable)
          begin
            applied    <= bl_ctrl.backlight_level_code;
            fade_state <= BLF_FADE_IDLE;
          end
          else if (step_due)
          begin
            if (applied < bl_ctrl.backlight_level_code)
              applied <= applied + 5'h01;
            else
              applied <= applied - 5'h01;
            if ((applied < bl_ctrl.backlight_level_code) ?
                (applied + 5'h01 == bl_ctrl.backlight_level_code) :
                (applied - 5'h01 == bl_ctrl.backlight_level_code))
              fade_state <= BLF_FADE_IDLE;
          end
        end
        default:
        begin
          fade_state <= BLF_FADE_IDLE;
          applied    <= bl_ctrl.backlight_level_code;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // backlight current decode and sink outputs
  // ------------------------------------------------------------
  always_comb
  begin
    if (applied <= BLF_BL_LINEAR_TOP)
      next_bl_current = {1'b0, applied} + 6'h01;
    else
      next_bl_current = BLF_BL_HIGH_TABLE[applied[2:0]];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sink_on            <= '0;
      bl_applied_code    <= BLF_RST_BL_CTRL[4:0];
      bl_current_half_ma <= '0;
      fade_busy          <= 1'b0;
    end
    else
    begin
      sink_on            <= sink_enable_bits[SINKS-1:0];
      bl_applied_code    <= applied;
      bl_current_half_ma <= next_bl_current;
      fade_busy          <= fading;
    end
  end

  // ------------------------------------------------------------
  // strobe time-out
  // ------------------------------------------------------------
  assign strobe_request = trig_sync && strobe_ctrl.strobe_level_code != '0;
  assign strobe_active  = strobe_request && !tripped;

  blf_ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS),
    .MS_W          (BLF_MS_W)
  ) u_strobe_timer (
    .mclk     (mclk),
    .rst      (rst),
    .clear    (!strobe_active),
    .ms_count (strobe_ms)
  );

  always_comb
  begin
    if (strobe_ctrl.strobe_range_select)
      limit_ms = BLF_FLASH_MAX_MS;
    else
      limit_ms = BLF_TIMEOUT_MS;
    limit_armed = strobe_ctrl.strobe_range_select ||
                  strobe_ctrl.strobe_timeout_enable;
  end

  assign trip_now = strobe_active && limit_armed && strobe_ms >= limit_ms;

  always_ff @(posedge mclk)
  begin
    if (rst)
      tripped <= 1'b0;
    else if (trip_now)
      tripped <= 1'b1;
    else if (!trig_sync || strobe_ctrl.strobe_level_code == '0)
      tripped <= 1'b0;
  end

  // ------------------------------------------------------------
  // strobe current decode and outputs
  // ------------------------------------------------------------
  always_comb
  begin
    if (strobe_ctrl.strobe_range_select)
      next_strobe_current =
        BLF_FLASH_TABLE[strobe_ctrl.strobe_level_code];
    else if ({1'b0, strobe_ctrl.strobe_level_code} > BLF_SPOT_MAX)
      next_strobe_current = BLF_SPOT_MAX;
    else
      next_strobe_current = {1'b0, strobe_ctrl.strobe_level_code};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      strobe_on           <= 1'b0;
      strobe_current_50ma <= '0;
      strobe_timed_out    <= 1'b0;
    end
    else
    begin
      strobe_on           <= strobe_active && !trip_now;
      strobe_current_50ma <= (strobe_active && !trip_now) ?
                             next_strobe_current : 4'h0;
      strobe_timed_out    <= tripped || trip_now;
    end
  end

  // ------------------------------------------------------------
  // read back
  // ------------------------------------------------------------
  always_comb
  begin
    case (reg_addr)
      BLF_ADDR_BL_CTRL:     next_rdata = bl_ctrl;
      BLF_ADDR_SINK_CTRL:   next_rdata = sink_enable_bits;
      BLF_ADDR_STROBE_CTRL: next_rdata = strobe_ctrl;
      default:              next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

endmodule // blf_regs
